// ---- verilog/gauge_cfg_pkg.sv ----
package gauge_cfg_pkg;

    // Register word offsets (byte addresses)
    localparam logic [3:0] OFS_MAIN = 4'h0;
    localparam logic [3:0] OFS_SEC = 4'h4;
    localparam logic [3:0] OFS_DBG = 4'h8;
    localparam logic [3:0] OFS_TIME = 4'hC;

    // Main option word fields
    localparam int MAIN_RESERVE_NOLOAD_COMP = 15;
    localparam int MAIN_GOOD_OVR = 14;
    localparam int MAIN_REM_IRQ = 13;
    localparam int MAIN_PFC_HI = 12;
    localparam int MAIN_PFC_LO = 11;
    localparam int MAIN_WAKE_RANGE = 10;
    localparam int MAIN_RSNS_HI = 9;
    localparam int MAIN_RSNS_LO = 8;
    localparam int MAIN_FOCV = 7;
    localparam int MAIN_SLEEP = 5;
    localparam int MAIN_LOAD_FULL = 4;
    localparam int MAIN_IRQ_POL = 3;
    localparam int MAIN_GOOD_POL = 2;
    localparam int MAIN_LOW_POL = 1;
    localparam int MAIN_TEMP_SRC = 0;

    // Secondary option byte fields
    localparam int SEC_TEMP_WR = 7;
    localparam int SEC_INS_DET = 6;
    localparam int SEC_GND_SEL = 4;
    localparam int SEC_GOOD_INIT = 3;
    localparam int SEC_WR_IND_PIN = 2;

    // Debug option byte: only the low three bits exist
    localparam logic [7:0] DBG_MASK = 8'h07;

    // Reset values
    localparam logic [15:0] MAIN_RESET = 16'h0973;
    localparam logic [7:0] SEC_RESET = 8'h53;
    localparam logic [7:0] DBG_RESET = 8'h00;
    localparam logic [2:0] BUS_TO_RESET = 3'h4;
    localparam logic [7:0] WR_WAIT_RESET = 8'h00;

    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int PULSE_US = 1000;
    localparam int PULSE_CYC = PULSE_US * (CLK_HZ / 1_000_000);
    localparam int WAIT_UNIT_US = 5;
    localparam int WAIT_UNIT_CYC = WAIT_UNIT_US * (CLK_HZ / 1_000_000);
    localparam int BUS_TO_UNIT_MS = 500;
    localparam int BUS_TO_UNIT_CYC = BUS_TO_UNIT_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        DV_AVERAGED,
        DV_INSTANT,
        DV_MINIMUM,
        DV_UNUSED
    } delta_sel_t;

    // Measurement inputs
    typedef struct packed {
        logic [15:0] voltage_mv;
        logic [15:0] sdown_clear_mv;
        logic [15:0] final_mv;
        logic signed [15:0] sense_uv;
        logic [15:0] avg_current_ma;
        logic [15:0] sleep_current_ma;
    } meas_t;

    // Gauge events
    typedef struct packed {
        logic sdown_set;
        logic removal;
        logic first_ocv;
        logic termination;
        logic init_active;
        logic hib_by_voltage;
        logic low_power;
        logic good_level;
        logic low_level;
        logic soc_level;
        logic bus_active;
        logic flash_req;
        logic host_temp_wr;
        logic host_detect_cmd;
        logic self_detect;
    } evt_t;

    // Decoded controls toward the gauge core
    typedef struct packed {
        logic reserve_noload_comp;
        logic [1:0] pin_function_mode;
        logic load_full_on_termination;
        logic temp_source_select;
        logic adc_ground_select;
        delta_sel_t delta_sel;
        logic sleep_allowed;
        logic host_temp_accept;
        logic battery_detected;
    } ctrl_t;

endpackage : gauge_cfg_pkg

// ---- verilog/gauge_config_option_bank.sv ----
// Functional notes
// [R1] Clear set shutdown flag above clear threshold
// [R2] Force charge level zero at final voltage
// [R3] Bit 15 enables no-load reserve compensation
// [R4] Bit 14 holds good output in voltage-hibernate
// [R5] Bit 13 pulses charge interrupt 1 ms on removal
// [R6] Bits 12,11 decode pin function mode 0-2
// [R7] Wake interrupt on threshold cross while asleep
// [R8] Resistor bits zero disable wake; else threshold table
// [R9] Bit 7 pulses charge interrupt on first OCV
// [R10] Bit 5 allows sleep at low average current
// [R11] Bit 4 loads full capacity on termination
// [R12] Bit 3 sets charge interrupt polarity
// [R13] Bit 2 sets battery-good polarity
// [R14] Bit 0 selects external or internal temperature
// [R15] Bus timeout zero none, else n times 0.5 s
// [R16] Flash write waits count times 5 us
// [R17] Secondary bit 7 accepts host temperature writes
// [R18] Secondary bit 6 off: host sets detected bit
// [R19] Secondary bit 4 selects ADC ground pin
// [R20] Secondary bit 3 allows good output during init
// [R21] Secondary bit 2 selects flash-write indicator pin
// [R22] Debug bits 1,0 select delta voltage method
// [R23] Debug reserved bits read zero, ignore writes
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module gauge_config_option_bank #(
    parameter int PULSE_CYCLES = gauge_cfg_pkg::PULSE_CYC,
    parameter int BUS_TO_UNIT_CYCLES = gauge_cfg_pkg::BUS_TO_UNIT_CYC
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic CLK_EN_IN,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    // Gauge side
    input wire gauge_cfg_pkg::meas_t MEAS_IN,
    input wire gauge_cfg_pkg::evt_t EVT_IN,
    output gauge_cfg_pkg::ctrl_t CTRL_OUT,
    output logic SYSTEM_SHUTDOWN_FLAG_OUT,
    output logic SOC_ZERO_OUT,
    output logic WAKE_IRQ_OUT,
    output logic FLASH_WRITE_GO_OUT,
    output logic BUS_TIMEOUT_OUT,
    // Pins
    output logic CHARGE_IRQ_OUT,
    output logic BATTERY_GOOD_OUT,
    output logic BATTERY_LOW_OUT
);
    import gauge_cfg_pkg::*;

    logic [15:0] main_q;
    logic [7:0] sec_q;
    logic [7:0] dbg_q;
    logic [2:0] bus_to_q;
    logic [7:0] wr_wait_q;
    logic ack_q;
    logic [31:0] rdata_d;
    logic [31:0] wdata_m;
    logic hit_main, hit_sec, hit_dbg, hit_time;
    logic wr_go;
    logic sdown_q, soc_zero_q, wake_q, detected_q;
    logic [31:0] pulse_cnt_q;
    logic [31:0] wait_cnt_q;
    logic [31:0] to_cnt_q;
    logic [15:0] wake_th;
    logic [15:0] sense_abs;
    logic wake_cross;
    logic irq_act, good_act, low_act, ind_act;
    logic goq, loq, ciq, fgo_q, to_q;

    typedef enum {FW_IDLE, FW_WAIT, FW_GO} fw_state_t;
    fw_state_t fw_q;

    // One wait state per access: ack follows the request by one edge
    assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;
    assign hit_main = AVS_ADDRESS_IN == OFS_MAIN;
    assign hit_sec = AVS_ADDRESS_IN == OFS_SEC;
    assign hit_dbg = AVS_ADDRESS_IN == OFS_DBG;
    assign hit_time = AVS_ADDRESS_IN == OFS_TIME;
    // A write lands only on the edge where waitrequest is seen low
    assign wr_go = CLK_EN_IN & AVS_WRITE_IN & ack_q;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wdata_m[i*8 +: 8] = AVS_BYTEENABLE_IN[i] ?
                AVS_WRITEDATA_IN[i*8 +: 8] : 8'h00;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ack_q <= 1'b0;
        end else if (CLK_EN_IN) begin
            ack_q <= (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            main_q <= MAIN_RESET;
            sec_q <= SEC_RESET;
            dbg_q <= DBG_RESET;
            bus_to_q <= BUS_TO_RESET;
            wr_wait_q <= WR_WAIT_RESET;
        end else if (wr_go) begin
            if (hit_main) begin
                if (AVS_BYTEENABLE_IN[0]) main_q[7:0] <= wdata_m[7:0];
                if (AVS_BYTEENABLE_IN[1]) main_q[15:8] <= wdata_m[15:8];
            end
            if (hit_sec && AVS_BYTEENABLE_IN[0]) begin
                sec_q <= wdata_m[7:0];
            end
            if (hit_dbg && AVS_BYTEENABLE_IN[0]) begin
                dbg_q <= wdata_m[7:0] & DBG_MASK; // R23
            end
            if (hit_time) begin
                if (AVS_BYTEENABLE_IN[0]) bus_to_q <= wdata_m[2:0];
                if (AVS_BYTEENABLE_IN[1]) wr_wait_q <= wdata_m[15:8];
            end
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (AVS_ADDRESS_IN)
            OFS_MAIN: rdata_d = {16'h0000, main_q};
            OFS_SEC: rdata_d = {24'h000000, sec_q};
            OFS_DBG: rdata_d = {24'h000000, dbg_q & DBG_MASK}; // R23
            OFS_TIME: rdata_d = {16'h0000, wr_wait_q, 5'h00, bus_to_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            AVS_READDATA_OUT <= 32'h0000_0000;
        end else if (CLK_EN_IN && AVS_READ_IN && !ack_q) begin
            AVS_READDATA_OUT <= rdata_d;
        end
    end

    // Shutdown flag: set by the gauge, cleared only once set
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sdown_q <= 1'b0;
        end else if (CLK_EN_IN) begin
            if (EVT_IN.sdown_set) begin
                sdown_q <= 1'b1;
            end else if (sdown_q &&
                         MEAS_IN.voltage_mv > MEAS_IN.sdown_clear_mv) begin
                sdown_q <= 1'b0; // R1
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            soc_zero_q <= 1'b0;
        end else if (CLK_EN_IN) begin
            soc_zero_q <= MEAS_IN.voltage_mv <= MEAS_IN.final_mv; // R2
        end
    end

    // Wake threshold in microvolts
    always_comb begin
        case ({main_q[MAIN_RSNS_HI], main_q[MAIN_RSNS_LO],
               main_q[MAIN_WAKE_RANGE]}) // R8
            3'b010: wake_th = 16'h04E2;
            3'b011: wake_th = 16'h09C4;
            3'b100: wake_th = 16'h09C4;
            3'b101: wake_th = 16'h1388;
            3'b110: wake_th = 16'h1388;
            3'b111: wake_th = 16'h2710;
            default: wake_th = 16'h0000;
        endcase
    end

    assign sense_abs = MEAS_IN.sense_uv[15] ? 16'(-MEAS_IN.sense_uv)
                                            : MEAS_IN.sense_uv;
    assign wake_cross = (wake_th != 16'h0000) && (sense_abs >= wake_th);

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wake_q <= 1'b0;
        end else if (CLK_EN_IN) begin
            wake_q <= EVT_IN.low_power & wake_cross; // R7
        end
    end

    // Detected bit: self detection or host command
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            detected_q <= 1'b0;
        end else if (CLK_EN_IN) begin
            if (EVT_IN.removal) begin
                detected_q <= 1'b0;
            end
            if (sec_q[SEC_INS_DET] ? EVT_IN.self_detect
                                   : EVT_IN.host_detect_cmd) begin
                detected_q <= 1'b1; // R18
            end
        end
    end

    // Charge-interrupt pulse; a new event restarts the full width
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pulse_cnt_q <= 32'h0000_0000;
        end else if (CLK_EN_IN) begin
            if ((EVT_IN.removal && main_q[MAIN_REM_IRQ]) || // R5
                (EVT_IN.first_ocv && main_q[MAIN_FOCV])) begin // R9
                pulse_cnt_q <= 32'(PULSE_CYCLES);
            end else if (pulse_cnt_q != 32'h0000_0000) begin
                pulse_cnt_q <= pulse_cnt_q - 32'h0000_0001;
            end
        end
    end

    // Flash write: indicate, wait count x 5 us, then go
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            fw_q <= FW_IDLE;
            wait_cnt_q <= 32'h0000_0000;
        end else if (CLK_EN_IN) begin
            case (fw_q)
                FW_IDLE: begin
                    if (EVT_IN.flash_req) begin
                        fw_q <= FW_WAIT;
                        wait_cnt_q <= 32'(wr_wait_q) * 32'(WAIT_UNIT_CYC);
                    end
                end
                FW_WAIT: begin
                    if (wait_cnt_q == 32'h0000_0000) begin
                        fw_q <= FW_GO; // R16
                    end else begin
                        wait_cnt_q <= wait_cnt_q - 32'h0000_0001;
                    end
                end
                FW_GO: begin
                    if (!EVT_IN.flash_req) begin
                        fw_q <= FW_IDLE;
                    end
                end
                default: fw_q <= FW_IDLE;
            endcase
        end
    end

    // Bus timeout counts while a transaction stays active
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            to_cnt_q <= 32'h0000_0000;
            to_q <= 1'b0;
        end else if (CLK_EN_IN) begin
            if (!EVT_IN.bus_active || bus_to_q == 3'h0) begin // R15
                to_cnt_q <= 32'h0000_0000;
                to_q <= 1'b0;
            end else if (to_cnt_q ==
                         32'(bus_to_q) * 32'(BUS_TO_UNIT_CYCLES)) begin
                to_q <= 1'b1;
            end else begin
                to_cnt_q <= to_cnt_q + 32'h0000_0001;
            end
        end
    end

    assign ind_act = fw_q != FW_IDLE;
    assign irq_act = EVT_IN.soc_level || pulse_cnt_q != 32'h0000_0000 ||
                     (ind_act && !sec_q[SEC_WR_IND_PIN]); // R21
    assign low_act = EVT_IN.low_level ||
                     (ind_act && sec_q[SEC_WR_IND_PIN]); // R21
    assign good_act = EVT_IN.init_active ? sec_q[SEC_GOOD_INIT] : // R20
                      (EVT_IN.good_level ||
                       (main_q[MAIN_GOOD_OVR] &&
                        EVT_IN.hib_by_voltage)); // R4

    // Pins registered so polarity changes never glitch
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ciq <= 1'b1;
            goq <= 1'b1;
            loq <= 1'b0;
            fgo_q <= 1'b0;
        end else if (CLK_EN_IN) begin
            ciq <= irq_act ~^ main_q[MAIN_IRQ_POL]; // R12
            goq <= good_act ~^ main_q[MAIN_GOOD_POL]; // R13
            loq <= low_act ~^ main_q[MAIN_LOW_POL];
            // Go drops on the first edge after the request falls, not a cycle later still
            fgo_q <= (fw_q == FW_GO) && EVT_IN.flash_req;
        end
    end

    always_comb begin
        CTRL_OUT.reserve_noload_comp = main_q[MAIN_RESERVE_NOLOAD_COMP]; // R3
        case ({main_q[MAIN_PFC_HI], main_q[MAIN_PFC_LO]}) // R6
            2'b00: CTRL_OUT.pin_function_mode = 2'h0;
            2'b01: CTRL_OUT.pin_function_mode = 2'h1;
            2'b10: CTRL_OUT.pin_function_mode = 2'h2;
            default: CTRL_OUT.pin_function_mode = 2'h1;
        endcase
        CTRL_OUT.load_full_on_termination =
            main_q[MAIN_LOAD_FULL] & EVT_IN.termination; // R11
        CTRL_OUT.temp_source_select = main_q[MAIN_TEMP_SRC]; // R14
        CTRL_OUT.adc_ground_select = sec_q[SEC_GND_SEL]; // R19
        CTRL_OUT.delta_sel = delta_sel_t'(dbg_q[1:0]); // R22
        CTRL_OUT.sleep_allowed = main_q[MAIN_SLEEP] &&
            MEAS_IN.avg_current_ma <= MEAS_IN.sleep_current_ma; // R10
        CTRL_OUT.host_temp_accept =
            sec_q[SEC_TEMP_WR] & EVT_IN.host_temp_wr; // R17
        CTRL_OUT.battery_detected = detected_q;
    end

    assign SYSTEM_SHUTDOWN_FLAG_OUT = sdown_q;
    assign SOC_ZERO_OUT = soc_zero_q; // R2
    assign WAKE_IRQ_OUT = wake_q;
    assign FLASH_WRITE_GO_OUT = fgo_q;
    assign BUS_TIMEOUT_OUT = to_q;
    assign CHARGE_IRQ_OUT = ciq;
    assign BATTERY_GOOD_OUT = goq;
    assign BATTERY_LOW_OUT = loq;

endmodule : gauge_config_option_bank
`default_nettype wire

// ---- verification/gauge_cfg_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module gauge_cfg_assertions #(
    parameter int PULSE_CYCLES = 20,
    parameter int BUS_TO_UNIT_CYCLES = 10
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic [3:0] AVS_ADDRESS_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic AVS_WAITREQUEST_OUT,
    input wire gauge_cfg_pkg::meas_t MEAS_IN,
    input wire gauge_cfg_pkg::evt_t EVT_IN,
    input wire gauge_cfg_pkg::ctrl_t CTRL_OUT,
    input wire logic SYSTEM_SHUTDOWN_FLAG_OUT,
    input wire logic SOC_ZERO_OUT,
    input wire logic WAKE_IRQ_OUT,
    input wire logic FLASH_WRITE_GO_OUT,
    input wire logic CHARGE_IRQ_OUT
);
    import gauge_cfg_pkg::*;
    logic [15:0] main_q;
    // Shadow of the main word so decodes are judged against what was written
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            main_q <= MAIN_RESET;
        end else if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT
                && AVS_ADDRESS_IN == OFS_MAIN) begin
            main_q <= AVS_WRITEDATA_IN[15:0];
        end
    end
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    property p_sdown_clear;
        SYSTEM_SHUTDOWN_FLAG_OUT && !EVT_IN.sdown_set
            && MEAS_IN.voltage_mv > MEAS_IN.sdown_clear_mv
            |=> !SYSTEM_SHUTDOWN_FLAG_OUT;
    endproperty
    a_sdown_clear: assert property (p_sdown_clear)
        else $error("shutdown flag kept above clear level");
    property p_sdown_hold;
        !SYSTEM_SHUTDOWN_FLAG_OUT && !EVT_IN.sdown_set
            |=> !SYSTEM_SHUTDOWN_FLAG_OUT;
    endproperty
    a_sdown_hold: assert property (p_sdown_hold)
        else $error("shutdown flag rose without a set event");
    property p_soc_zero;
        MEAS_IN.voltage_mv <= MEAS_IN.final_mv |=> SOC_ZERO_OUT;
    endproperty
    a_soc_zero: assert property (p_soc_zero)
        else $error("charge level not forced to zero");
    property p_removal;
        main_q[13] && EVT_IN.removal
            |=> ##1 (CHARGE_IRQ_OUT == main_q[3]) [*8];
    endproperty
    a_removal: assert property (p_removal)
        else $error("removal pulse missing or short");
    property p_pfc;
        CTRL_OUT.pin_function_mode == {main_q[12] & ~main_q[11], main_q[11]};
    endproperty
    a_pfc: assert property (p_pfc)
        else $error("pin function mode wrong");
    property p_wake_on;
        EVT_IN.low_power && main_q[10:8] == 3'h7
            && MEAS_IN.sense_uv >= 16'sh2710 |=> WAKE_IRQ_OUT;
    endproperty
    a_wake_on: assert property (p_wake_on)
        else $error("wake not raised at top threshold");
    property p_wake_off;
        EVT_IN.low_power && main_q[9:8] == 2'h0 |=> !WAKE_IRQ_OUT;
    endproperty
    a_wake_off: assert property (p_wake_off)
        else $error("wake raised while detection disabled");
    property p_go_hold;
        !EVT_IN.flash_req |=> !FLASH_WRITE_GO_OUT;
    endproperty
    a_go_hold: assert property (p_go_hold)
        else $error("flash write go without request");
endmodule : gauge_cfg_assertions
`default_nettype wire

// ---- verification/host_bus_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
    input wire logic clk_in,
    input wire logic wait_in,
    input wire logic [31:0] rdata_in,
    output logic [3:0] addr_out,
    output logic rd_out,
    output logic wr_out,
    output logic [31:0] wdata_out
);
    initial begin
        addr_out = 4'h0;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 32'h0;
    end
    // Enter just after a rising edge; the request is held until accepted
    task automatic xfer(input logic w, input logic [3:0] a,
            input logic [31:0] d, output logic [31:0] q);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= w;
        rd_out <= !w;
        do @(posedge clk_in); while (wait_in !== 1'b0);
        q = rdata_in;
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        // Released lines never keep the last value
        addr_out <= ~a;
        wdata_out <= ~d;
        @(posedge clk_in);
    endtask : xfer
endmodule : host_bus_model
`default_nettype wire

// ---- verification/gauge_config_option_bank_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module gauge_config_option_bank_tb;
    import gauge_cfg_pkg::*;
    localparam int PULSE_CYCLES = 20;
    localparam int BUS_TO_UNIT_CYCLES = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    meas_t meas;
    evt_t evt;
    ctrl_t ctrl;
    logic [3:0] addr;
    logic rd, wr, waitreq, sdown, soc0, wake, go, bto, irq, good, low;
    logic [31:0] wdata, rdata, q;
    int err_count = 0;
    int n_checks = 0;
    always #5 clk = ~clk;
    host_bus_model host (.clk_in(clk), .wait_in(waitreq), .rdata_in(rdata),
        .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wdata));
    gauge_config_option_bank #(.PULSE_CYCLES(PULSE_CYCLES),
        .BUS_TO_UNIT_CYCLES(BUS_TO_UNIT_CYCLES)) dut (
        .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(clk_en),
        .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hF),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
        .MEAS_IN(meas), .EVT_IN(evt), .CTRL_OUT(ctrl),
        .SYSTEM_SHUTDOWN_FLAG_OUT(sdown), .SOC_ZERO_OUT(soc0),
        .WAKE_IRQ_OUT(wake), .FLASH_WRITE_GO_OUT(go),
        .BUS_TIMEOUT_OUT(bto), .CHARGE_IRQ_OUT(irq),
        .BATTERY_GOOD_OUT(good), .BATTERY_LOW_OUT(low));
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wr_reg
    task automatic rd_chk(string what, logic [3:0] a, logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, q);
        check(what, q, e);
    endtask : rd_chk
    task automatic t_reset;
        check("irq idle", irq, 1'b1);
        check("good idle", good, 1'b1);
        check("temp src", ctrl.temp_source_select, 1'b1);
        check("gnd sel", ctrl.adc_ground_select, 1'b1);
        check("soc idle", soc0, 1'b0);
        rd_chk("main", OFS_MAIN, 32'h0973);
        rd_chk("sec", OFS_SEC, 32'h0053);
        rd_chk("time", OFS_TIME, 32'h0004);
    endtask : t_reset
    task automatic t_regs;
        wr_reg(OFS_DBG, 32'hFF);
        rd_chk("dbg", OFS_DBG, 32'h07);
        for (int k = 0; k < 4; k++) begin
            wr_reg(OFS_DBG, 32'(k));
            check("dsel", ctrl.delta_sel, 32'(k));
            wr_reg(OFS_MAIN, 32'h800C | (32'(k) << 11));
            step(2);
            check("pfc", ctrl.pin_function_mode, (k == 3) ? 1 : k);
            check("reserve_noload_comp", ctrl.reserve_noload_comp, 1'b1);
            check("temp int", ctrl.temp_source_select, 1'b0);
            check("no sleep", ctrl.sleep_allowed, 1'b0);
            check("irq high", irq, 1'b0);
            check("good high", good, 1'b0);
        end
        wr_reg(4'h6, 32'hFFFF);
        rd_chk("hole", 4'h6, 32'h0);
        wr_reg(OFS_MAIN, 32'h0973);
        check("sleep", ctrl.sleep_allowed, 1'b1);
        rd_chk("main", OFS_MAIN, 32'h0973);
    endtask : t_regs
    task automatic t_volt;
        meas.voltage_mv <= 16'h0CE4;
        evt.sdown_set <= 1'b1;
        step(1);
        evt.sdown_set <= 1'b0;
        step(3);
        check("sdown set", sdown, 1'b1);
        meas.voltage_mv <= 16'h0D48;
        step(3);
        check("sdown at clr", sdown, 1'b1);
        meas.voltage_mv <= 16'h0D49;
        step(3);
        check("sdown clr", sdown, 1'b0);
        meas.voltage_mv <= 16'h0BB8;
        step(3);
        check("soc zero", soc0, 1'b1);
        meas.voltage_mv <= 16'h0E10;
    endtask : t_volt
    task automatic t_pulse;
        int n;
        for (int en = 1; en >= 0; en--) begin
            wr_reg(OFS_MAIN, 32'h0973 | (32'(en) << 13));
            n = 0;
            evt.removal <= 1'b1;
            step(1);
            evt.removal <= 1'b0;
            repeat (PULSE_CYCLES + 8) begin
                @(posedge clk);
                n += (irq === 1'b0);
            end
            check("pulse", n, en * PULSE_CYCLES);
        end
    endtask : t_pulse
    task automatic t_wake;
        int thr[8] = '{0, 0, 16'h04E2, 16'h09C4, 16'h09C4, 16'h1388,
            16'h1388, 16'h2710};
        int v;
        evt.low_power <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            // Index k is {sense resistor bits, range bit}
            wr_reg(OFS_MAIN, 32'h0073 | (32'(k >> 1) << 8) |
                (32'(k & 1) << 10));
            for (int s = 0; s < 3; s++) begin
                v = (k < 2) ? 16'h2710 : thr[k];
                meas.sense_uv <= 16'((s == 1) ? -v : v - s / 2);
                step(3);
                check("wake", wake, (k >= 2) && (s < 2));
            end
        end
        evt.low_power <= 1'b0;
        meas.sense_uv <= 16'sh2710;
        step(3);
        check("wake awake", wake, 1'b0);
        meas.sense_uv <= 16'sh0;
        wr_reg(OFS_MAIN, 32'h0973);
    endtask : t_wake
    task automatic t_flash;
        int n;
        wr_reg(OFS_TIME, 32'h0204);
        for (int p = 0; p < 2; p++) begin
            wr_reg(OFS_SEC, 32'h53 | (32'(p) << 2));
            n = 0;
            evt.flash_req <= 1'b1;
            do begin
                @(posedge clk);
                n++;
            end while (go !== 1'b1 && n < 1200);
            check("go wait", (n > 1000) && (n < 1006), 1'b1);
            check("ind soc", irq, p);
            check("ind low", low, p);
            evt.flash_req <= 1'b0;
            step(3);
            check("go off", go, 1'b0);
        end
    endtask : t_flash
    task automatic t_timeout;
        evt.bus_active <= 1'b1;
        // Counting must stand still while the enable is low
        clk_en <= 1'b0;
        step(30);
        clk_en <= 1'b1;
        step(4 * BUS_TO_UNIT_CYCLES - 2);
        check("bto early", bto, 1'b0);
        step(4);
        check("bto", bto, 1'b1);
        wr_reg(OFS_TIME, 32'h0000);
        step(3);
        check("bto none", bto, 1'b0);
        evt.bus_active <= 1'b0;
    endtask : t_timeout
    task automatic t_misc;
        evt.host_temp_wr <= 1'b1;
        evt.termination <= 1'b1;
        evt.host_detect_cmd <= 1'b1;
        evt.hib_by_voltage <= 1'b1;
        step(2);
        check("temp wr off", ctrl.host_temp_accept, 1'b0);
        check("full load", ctrl.load_full_on_termination, 1'b1);
        check("self detect", ctrl.battery_detected, 1'b0);
        check("good ovr off", good, 1'b1);
        wr_reg(OFS_MAIN, 32'h4973);
        wr_reg(OFS_SEC, 32'h93);
        step(2);
        check("temp wr on", ctrl.host_temp_accept, 1'b1);
        check("host detect", ctrl.battery_detected, 1'b1);
        check("good ovr on", good, 1'b0);
        evt <= '0;
    endtask : t_misc
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    initial begin
        meas = '{16'h0E10, 16'h0D48, 16'h0BB8, 16'sh0, 16'h5, 16'hA};
        evt = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_regs();
        t_volt();
        t_pulse();
        t_wake();
        t_flash();
        t_timeout();
        t_misc();
        wrap_up();
    end
    // Whole run needs about 2400 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule : gauge_config_option_bank_tb
bind gauge_config_option_bank gauge_cfg_assertions #(
    .PULSE_CYCLES(PULSE_CYCLES), .BUS_TO_UNIT_CYCLES(BUS_TO_UNIT_CYCLES)
) u_chk (.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN),
    .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
    .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
    .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .MEAS_IN(MEAS_IN),
    .EVT_IN(EVT_IN), .CTRL_OUT(CTRL_OUT),
    .SYSTEM_SHUTDOWN_FLAG_OUT(SYSTEM_SHUTDOWN_FLAG_OUT),
    .SOC_ZERO_OUT(SOC_ZERO_OUT), .WAKE_IRQ_OUT(WAKE_IRQ_OUT),
    .FLASH_WRITE_GO_OUT(FLASH_WRITE_GO_OUT),
    .CHARGE_IRQ_OUT(CHARGE_IRQ_OUT));
`default_nettype wire
